// ==== core/ufhc_core.sv ====
// Overview of operation
// RQ1: Operational controls exposed as plain ports
// RQ2: Master fetches descriptors, retires transfer descriptors
// RQ3: Bus error or misalignment sets fatal flag
// RQ4: Downstream port count readable by software
// RQ5: Per-port attach detect; undriven D+ reads connected; the core flags a port connected only while D+ or D- is high
// RQ6: Only controller drives transceiver line pairs
// RQ7: Activatable per-port overcurrent power cut
// RQ8: System supplies accurate 48 MHz clock; the core here runs from a 100 MHz clock (CLK_MHZ)
// RQ9: Line logic runs on recovered 12 MHz rate
// RQ10: Interrupt controller programmed before host port
// RQ11: Control, status and list pointer set present
// RQ12: Target for controls, master for shared area; here the controls are plain input ports and only the master exists
// RQ13: Shared area holds list heads, done head, frame
// RQ14: Endpoint descriptor four words, transfer four/eight
// RQ15: Walk each endpoint's transfer descriptor queue
// RQ16: Half-duplex full speed plus low speed
// RQ17: Up to 127 device addresses
// RQ18: Asynchronous line inputs synchronised before use
`timescale 1ns/1ns
module ufhc_core
   import ufhc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic                     runEnable,                // RQ1
   input  wire logic [31:0]              hccaBase,                 // RQ11
   input  wire logic                     clearFatal,
   input  wire logic [NPORTS-1:0]        portResetReq,
   input  wire logic [NPORTS-1:0]        ocProtectEnable,
   input  wire logic [NPORTS-1:0]        ocSense,
   input  wire logic [NPORTS-1:0]        hdpIn,
   input  wire logic [NPORTS-1:0]        hdmIn,
   input  wire ufhc_mem_rsp_t            memRsp,
   output logic                          memReq,
   output ufhc_mem_cmd_t                 memCmd,
   output ufhc_line_t [NPORTS-1:0]       line,
   output logic [NPORTS-1:0]             portConnected,
   output logic [NPORTS-1:0]             portLowSpeed,
   output logic [NPORTS-1:0]             portPowerOn,
   output logic [3:0]                    downstreamPortCount,
   output logic                          fatalBusError,
   output logic [15:0]                   frameNumber,
   output logic [6:0]                    currentDevAddr,
   output logic                          currentLowSpeed
);

   ufhc_regs_t s;
   ufhc_regs_t next_s;
   logic       bitTick;
   logic       busy;
   logic [6:0] phaseSum;
   logic [2:0] tdLast;

   // Bit-rate enable for the 12 MHz line domain
   assign phaseSum = s.phase + 7'(BIT_MHZ);                        // RQ9
   assign bitTick  = (phaseSum >= 7'(CLK_MHZ));                    // RQ9

   // Master handshake: request stands while in an access state
   assign busy   = (s.fsm != S_IDLE) && (s.fsm != S_ED_CHK) && (s.fsm != S_FAULT);
   assign memReq = busy;                                           // RQ12
   assign memCmd = s.cmd;
   assign tdLast = s.edWord[0][ED_ISO_BIT] ? 3'(TD_ISO_WORDS - 1)
                                           : 3'(TD_GEN_WORDS - 1); // RQ14

   // Outputs
   assign portConnected       = s.connected;
   assign portLowSpeed        = s.lowSpeedDev;
   assign portPowerOn         = s.powerOn;
   assign downstreamPortCount = 4'(NPORTS);                        // RQ4
   assign fatalBusError       = s.fatal;
   assign frameNumber         = s.frameNum;
   assign currentDevAddr      = s.devAddr;
   assign currentLowSpeed     = s.lowSpeedXfer;

   // Transceiver drive: reset signalling only, owned by the root hub
   genvar p;
   generate
      for (p = 0; p < NPORTS; p++)
      begin : g_line
         assign line[p].oe    = portResetReq[p];                   // RQ6
         assign line[p].dpOut = 1'b0;
         assign line[p].dmOut = 1'b0;
      end
   endgenerate

   // Next-state logic
   always_comb
   begin
      next_s = s;
      // Line input synchronisers and port status
      next_s.dpMeta      = hdpIn;                                  // RQ18
      next_s.dmMeta      = hdmIn;                                  // RQ18
      next_s.dpSync      = s.dpMeta;
      next_s.dmSync      = s.dmMeta;
      next_s.connected   = s.dpSync | s.dmSync;                    // RQ5
      next_s.lowSpeedDev = s.dmSync & ~s.dpSync;                   // RQ16
      next_s.powerOn     = ~(ocProtectEnable & ocSense);           // RQ7

      // Bit and frame timing
      next_s.phase = bitTick ? 7'(phaseSum - 7'(CLK_MHZ)) : phaseSum;
      if (bitTick)
      begin
         if (s.bitCnt == 14'(FRAME_BITS - 1))
         begin
            next_s.bitCnt     = '0;
            next_s.frameNum   = s.frameNum + 16'h0001;
            next_s.sofPending = 1'b1;
         end
         else
         begin
            next_s.bitCnt = s.bitCnt + 14'h0001;
         end
      end

      // Fatal flag: a fresh fault wins over a clear
      if (clearFatal)
      begin
         next_s.fatal = 1'b0;
      end

      case (s.fsm)
         S_IDLE:
         begin
            if (runEnable && s.sofPending && !s.fatal)
            begin
               next_s.cmd = '{we: 1'b1, addr: hccaBase + SHARED_COMM_AREA_FRAME_OFS,
                              wdata: {16'h0000, s.frameNum}};      // RQ13
               next_s.fsm = S_SOF_WR;
            end
         end
         S_SOF_WR:
         begin
            if (memRsp.ack)
            begin
               next_s.cmd = '{we: 1'b0, addr: hccaBase + {25'h0, s.frameNum[4:0], 2'b00},
                              wdata: 32'h0};                       // RQ13
               next_s.fsm = S_SHARED_COMM_AREA_RD;
            end
         end
         S_SHARED_COMM_AREA_RD:
         begin
            if (memRsp.ack)
            begin
               next_s.edPtr = memRsp.rdata;
               next_s.wIdx  = '0;
               next_s.cmd   = '{we: 1'b0, addr: memRsp.rdata, wdata: 32'h0};
               if (memRsp.rdata == 32'h0)
               begin
                  next_s.fsm = S_IDLE;
               end
               else if (memRsp.rdata[3:0] != 4'h0)
               begin
                  next_s.fsm = S_FAULT;                            // RQ3
               end
               else
               begin
                  next_s.fsm = S_ED_RD;
               end
            end
         end
         S_ED_RD:
         begin
            if (memRsp.ack)
            begin
               next_s.edWord[s.wIdx[1:0]] = memRsp.rdata;          // RQ14
               next_s.wIdx     = s.wIdx + 3'h1;
               next_s.cmd.addr = s.cmd.addr + 32'h4;
               if (s.wIdx == 3'(ED_WORDS - 1))
               begin
                  next_s.fsm = S_ED_CHK;
               end
            end
         end
         S_ED_CHK:
         begin
            next_s.devAddr      = s.edWord[0][ED_ADDR_MSB:0];      // RQ17
            next_s.lowSpeedXfer = s.edWord[0][ED_SPEED_BIT];       // RQ16
            next_s.wIdx         = '0;
            next_s.sofPending   = 1'b0;
            if (s.edWord[0][ED_SKIP_BIT]
                || (s.edWord[2][31:4] == s.edWord[1][31:4]))
            begin
               // Skipped or queue empty: go to next endpoint in the list
               next_s.edPtr = s.edWord[3];                         // RQ15
               next_s.cmd   = '{we: 1'b0, addr: s.edWord[3], wdata: 32'h0};
               if (s.edWord[3] == 32'h0)
               begin
                  next_s.fsm = S_IDLE;
               end
               else if (s.edWord[3][3:0] != 4'h0)
               begin
                  next_s.fsm = S_FAULT;                            // RQ3
               end
               else
               begin
                  next_s.fsm = S_ED_RD;
               end
            end
            else
            begin
               next_s.tdPtr = {s.edWord[2][31:4], 4'h0};
               next_s.cmd   = '{we: 1'b0, addr: {s.edWord[2][31:4], 4'h0}, wdata: 32'h0};
               next_s.fsm   = S_TD_RD;                             // RQ15
            end
         end
         S_TD_RD:
         begin
            if (memRsp.ack)
            begin
               if (s.wIdx < 3'(TD_GEN_WORDS))
               begin
                  next_s.tdWord[s.wIdx[1:0]] = memRsp.rdata;
               end
               next_s.wIdx     = s.wIdx + 3'h1;
               next_s.cmd.addr = s.cmd.addr + 32'h4;
               if (s.wIdx == tdLast)
               begin
                  next_s.cmd = '{we: 1'b1, addr: s.tdPtr,
                                 wdata: {TD_CC_OK, s.tdWord[0][27:0]}}; // RQ2
                  next_s.fsm = S_TD_WB0;                           // RQ14
               end
            end
         end
         S_TD_WB0:
         begin
            if (memRsp.ack)
            begin
               next_s.cmd = '{we: 1'b1, addr: s.tdPtr + TD_NEXT_OFS,
                              wdata: s.doneHead};                  // RQ2
               next_s.fsm = S_TD_WB2;
            end
         end
         S_TD_WB2:
         begin
            if (memRsp.ack)
            begin
               next_s.doneHead  = s.tdPtr;
               next_s.edWord[2] = {s.tdWord[2][31:4], s.edWord[2][3:0]};
               next_s.cmd = '{we: 1'b1, addr: s.edPtr + ED_HEAD_OFS,
                              wdata: {s.tdWord[2][31:4], s.edWord[2][3:0]}}; // RQ15
               next_s.fsm = S_ED_WB;
            end
         end
         S_ED_WB:
         begin
            if (memRsp.ack)
            begin
               next_s.cmd = '{we: 1'b1, addr: hccaBase + SHARED_COMM_AREA_DONE_OFS,
                              wdata: s.doneHead};                  // RQ13
               next_s.fsm = S_DONE_WR;
            end
         end
         S_DONE_WR:
         begin
            if (memRsp.ack)
            begin
               next_s.fsm = S_ED_CHK;
            end
         end
         S_FAULT:
         begin
            if (clearFatal)
            begin
               next_s.fsm = S_IDLE;
            end
         end
         default:
         begin
            next_s.fsm = S_IDLE;
         end
      endcase

      // Any bus abort during an access is fatal
      if (busy && memRsp.err)
      begin
         next_s.fsm = S_FAULT;                                     // RQ3
      end
      if (next_s.fsm == S_FAULT && s.fsm != S_FAULT)
      begin
         next_s.fatal = 1'b1;                                      // RQ3
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s <= UFHC_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence seq_dp_high;
      hdpIn[0] [*4];
   endsequence

   sequence seq_ed_misaligned;
      s.fsm == S_SHARED_COMM_AREA_RD && memRsp.ack && !memRsp.err
      && memRsp.rdata != 32'h0 && memRsp.rdata[3:0] != 4'h0;
   endsequence

   sequence seq_next_misaligned;
      s.fsm == S_ED_CHK && s.edWord[3] != 32'h0 && s.edWord[3][3:0] != 4'h0
      && (s.edWord[0][ED_SKIP_BIT] || s.edWord[2][31:4] == s.edWord[1][31:4]);
   endsequence

   chk_abort_fatal: assert property (busy && memRsp.err |=> fatalBusError) // RQ3
      else $error("bus abort did not raise fatal flag");
   chk_misalign_fatal: assert property (seq_ed_misaligned |=> fatalBusError && !memReq) // RQ3
      else $error("misaligned descriptor not flagged");
   chk_next_misalign: assert property (seq_next_misaligned |=> fatalBusError && !memReq) // RQ3
      else $error("misaligned next endpoint not flagged");
   chk_fatal_sticky: assert property (fatalBusError && !clearFatal |=> fatalBusError) // RQ3
      else $error("fatal flag dropped without clear");
   chk_port_count: assert property (downstreamPortCount == 4'(NPORTS)) // RQ4
      else $error("port count wrong");
   chk_attach_detect: assert property (seq_dp_high |=> portConnected[0]) // RQ5
      else $error("attach not detected");
   chk_line_idle: assert property (!portResetReq[0] |-> !line[0].oe) // RQ6
      else $error("line driven without controller request");
   chk_overcurrent_cut: assert property (ocProtectEnable[0] && ocSense[0] |=> !portPowerOn[0]) // RQ7
      else $error("overcurrent did not cut power");
   chk_bit_rate: assert property (bitTick |=> !bitTick ##1 !bitTick) // RQ9
      else $error("bit enable faster than line rate");
   chk_sof_write: assert property (s.fsm == S_IDLE && runEnable && s.sofPending && !s.fatal
      |=> memReq && memCmd.we && memCmd.addr == hccaBase + SHARED_COMM_AREA_FRAME_OFS) // RQ13
      else $error("frame number not written to shared area");
   chk_td_length: assert property (s.fsm == S_TD_RD && memRsp.ack && !memRsp.err
      && s.wIdx == 3'(TD_GEN_WORDS - 1) && !s.edWord[0][ED_ISO_BIT] |=> s.fsm == S_TD_WB0) // RQ14
      else $error("general descriptor length wrong");

endmodule

// ==== core/ufhc_pkg.sv ====
package ufhc_pkg;

   // Root hub size
   localparam int NPORTS = 2;

   // Bit-rate generation: line bit rate derived from the 100 MHz clock
   localparam int CLK_MHZ     = 100;
   localparam int BIT_MHZ     = 12;
   localparam int FRAME_BITS  = 12000;   // 1 ms frame at 12 Mbit/s

   // Shared communication area offsets (bytes)
   localparam logic [31:0] SHARED_COMM_AREA_FRAME_OFS = 32'h0000_0080;
   localparam logic [31:0] SHARED_COMM_AREA_DONE_OFS  = 32'h0000_0084;

   // Descriptor field positions
   localparam int ED_ADDR_MSB  = 6;
   localparam int ED_SPEED_BIT = 13;
   localparam int ED_SKIP_BIT  = 14;
   localparam int ED_ISO_BIT   = 15;
   localparam int ED_WORDS     = 4;
   localparam int TD_GEN_WORDS = 4;
   localparam int TD_ISO_WORDS = 8;
   localparam logic [3:0] TD_CC_OK = 4'h0;

   // Byte offsets of descriptor words
   localparam logic [31:0] ED_HEAD_OFS = 32'h0000_0008;
   localparam logic [31:0] TD_NEXT_OFS = 32'h0000_0008;

   typedef enum logic [3:0] {
      S_IDLE    = 4'h0,
      S_SOF_WR  = 4'h1,
      S_SHARED_COMM_AREA_RD = 4'h2,
      S_ED_RD   = 4'h3,
      S_ED_CHK  = 4'h4,
      S_TD_RD   = 4'h5,
      S_TD_WB0  = 4'h6,
      S_TD_WB2  = 4'h7,
      S_ED_WB   = 4'h8,
      S_DONE_WR = 4'h9,
      S_FAULT   = 4'hA
   } ufhc_fsm_t;

   // Master command toward system memory
   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ufhc_mem_cmd_t;

   // Answer from system memory
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } ufhc_mem_rsp_t;

   // Transceiver drive for one port
   typedef struct packed {
      logic dpOut;
      logic dmOut;
      logic oe;
   } ufhc_line_t;

   // Whole state of the controller
   typedef struct packed {
      ufhc_fsm_t                fsm;
      ufhc_mem_cmd_t            cmd;
      logic [31:0]              edPtr;
      logic [31:0]              tdPtr;
      logic [31:0]              doneHead;
      logic [ED_WORDS-1:0][31:0] edWord;
      logic [TD_GEN_WORDS-1:0][31:0] tdWord;
      logic [2:0]               wIdx;
      logic [6:0]               phase;
      logic [13:0]              bitCnt;
      logic [15:0]              frameNum;
      logic                     sofPending;
      logic                     fatal;
      logic [6:0]               devAddr;
      logic                     lowSpeedXfer;
      logic [NPORTS-1:0]        dpMeta;
      logic [NPORTS-1:0]        dmMeta;
      logic [NPORTS-1:0]        dpSync;
      logic [NPORTS-1:0]        dmSync;
      logic [NPORTS-1:0]        connected;
      logic [NPORTS-1:0]        lowSpeedDev;
      logic [NPORTS-1:0]        powerOn;
   } ufhc_regs_t;

   localparam ufhc_regs_t UFHC_RESET = '0;

endpackage

// ==== testbench/ufhc_core_tb_top.sv ====
`timescale 1ns/1ns
module ufhc_core_tb_top
   import ufhc_pkg::*;
;
   logic                    clk;
   logic                    sys_rst;
   logic                    runEnable;
   logic [31:0]             hccaBase;
   logic                    clearFatal;
   logic [NPORTS-1:0]       portResetReq;
   logic [NPORTS-1:0]       ocProtectEnable;
   logic [NPORTS-1:0]       ocSense;
   logic [NPORTS-1:0]       hdpIn;
   logic [NPORTS-1:0]       hdmIn;
   ufhc_mem_rsp_t           memRsp;
   logic                    memReq;
   ufhc_mem_cmd_t           memCmd;
   ufhc_line_t [NPORTS-1:0] line;
   logic [NPORTS-1:0]       portConnected;
   logic [NPORTS-1:0]       portLowSpeed;
   logic [NPORTS-1:0]       portPowerOn;
   logic [3:0]              downstreamPortCount;
   logic                    fatalBusError;
   logic [15:0]             frameNumber;
   logic [6:0]              currentDevAddr;
   logic                    currentLowSpeed;
   int                      fails;
   int                      compares;

   ufhc_core dut_u (.clk(clk), .sys_rst(sys_rst), .runEnable(runEnable),
      .hccaBase(hccaBase), .clearFatal(clearFatal), .portResetReq(portResetReq),
      .ocProtectEnable(ocProtectEnable), .ocSense(ocSense), .hdpIn(hdpIn),
      .hdmIn(hdmIn), .memRsp(memRsp), .memReq(memReq), .memCmd(memCmd),
      .line(line), .portConnected(portConnected), .portLowSpeed(portLowSpeed),
      .portPowerOn(portPowerOn), .downstreamPortCount(downstreamPortCount),
      .fatalBusError(fatalBusError), .frameNumber(frameNumber),
      .currentDevAddr(currentDevAddr), .currentLowSpeed(currentLowSpeed));

   ufhc_mem_model mdl_u (.clk(clk), .memReq(memReq), .memCmd(memCmd),
      .slowMode(1'b1), .memRsp(memRsp));

   // Free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Case-equal comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Root hub port count
   task automatic test_port_count();
      chk(downstreamPortCount, 32'h2, "port count");
      $display("test_port_count done");
   endtask

   // Attach detection with full and low speed devices
   task automatic test_attach();
      @(posedge clk);
      hdpIn <= 2'b01;
      hdmIn <= 2'b10;
      repeat (4) @(posedge clk);
      #1;
      chk(portConnected, 32'h3, "connected");
      chk(portLowSpeed, 32'h2, "low speed");
      @(posedge clk);
      hdpIn <= 2'b00;
      hdmIn <= 2'b00;
      repeat (4) @(posedge clk);
      #1;
      chk(portConnected, 32'h0, "detached");
      $display("test_attach done");
   endtask

   // Port reset drives SE0 only on the chosen port
   task automatic test_line_drive();
      @(posedge clk);
      portResetReq <= 2'b10;
      #1;
      chk({line[1], line[0]}, {26'h0, 6'b001000}, "line drive");
      @(posedge clk);
      portResetReq <= 2'b00;
      #1;
      chk({line[1].oe, line[0].oe}, 32'h0, "line released");
      $display("test_line_drive done");
   endtask

   // Overcurrent cut only where protection is enabled
   task automatic test_overcurrent();
      @(posedge clk);
      ocProtectEnable <= 2'b01;
      ocSense         <= 2'b11;
      repeat (2) @(posedge clk);
      #1;
      chk(portPowerOn, 32'h2, "power cut");
      @(posedge clk);
      ocSense <= 2'b00;
      repeat (2) @(posedge clk);
      #1;
      chk(portPowerOn, 32'h3, "power back");
      $display("test_overcurrent done");
   endtask

   // One frame: retire a transfer, then a misaligned next endpoint faults
   task automatic test_frame();
      int n;
      @(posedge clk);
      runEnable <= 1'b1;
      n = 0;
      while (fatalBusError !== 1'b1 && n < 100300)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 100300)
      begin
         fails++;
         $display("mismatch at %0t: frame never faulted", $time);
         give_verdict();
      end
      repeat (2) @(posedge clk);
      #1;
      chk(memReq, 32'h0, "no access after fault");
      chk(frameNumber, 32'h1, "frame number");
      chk(mdl_u.mem[32'h0000_1080], 32'h1, "frame written");
      chk(mdl_u.mem[32'h0000_3000], 32'h0012_0000, "td status");
      chk(mdl_u.mem[32'h0000_3008], 32'h0, "td done link");
      chk(mdl_u.mem[32'h0000_2008], 32'h0000_3100, "ed head");
      chk(mdl_u.mem[32'h0000_1084], 32'h0000_3000, "done head");
      chk(mdl_u.rdCnt, 32'd9, "reads");
      chk(mdl_u.wrCnt, 32'd5, "writes");
      chk(currentDevAddr, 32'h5, "device address");
      chk(currentLowSpeed, 32'h1, "endpoint speed");
      $display("test_frame done");
   endtask

   // Clearing the sticky fault
   task automatic test_clear();
      @(posedge clk);
      runEnable  <= 1'b0;
      clearFatal <= 1'b1;
      @(posedge clk);
      clearFatal <= 1'b0;
      @(posedge clk);
      #1;
      chk(fatalBusError, 32'h0, "fault cleared");
      $display("test_clear done");
   endtask

   // Memory image, reset, then scenarios
   initial
   begin
      fails           = 0;
      compares        = 0;
      sys_rst         = 1'b1;
      runEnable       = 1'b0;
      hccaBase        = 32'h0000_1000;
      clearFatal      = 1'b0;
      portResetReq    = '0;
      ocProtectEnable = '0;
      ocSense         = '0;
      hdpIn           = '0;
      hdmIn           = '0;
      mdl_u.mem[32'h0000_1000] = 32'h0000_2000;
      mdl_u.mem[32'h0000_1004] = 32'h0000_2000;
      mdl_u.mem[32'h0000_2000] = 32'h0000_2005;
      mdl_u.mem[32'h0000_2004] = 32'h0000_3100;
      mdl_u.mem[32'h0000_2008] = 32'h0000_3000;
      mdl_u.mem[32'h0000_200C] = 32'h0000_2208;
      mdl_u.mem[32'h0000_3000] = 32'hE012_0000;
      mdl_u.mem[32'h0000_3004] = 32'h0000_4000;
      mdl_u.mem[32'h0000_3008] = 32'h0000_3100;
      mdl_u.mem[32'h0000_300C] = 32'h0000_4003;
      repeat (5) @(posedge clk);
      #1;
      chk(memReq, 32'h0, "idle in reset");
      chk(fatalBusError, 32'h0, "flag in reset");
      chk(portPowerOn, 32'h0, "power off in reset");
      @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      test_port_count();
      test_attach();
      test_line_drive();
      test_overcurrent();
      test_frame();
      test_clear();
      give_verdict();
   end
endmodule

// ==== testbench/ufhc_mem_model.sv ====
`timescale 1ns/1ns
module ufhc_mem_model
   import ufhc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          memReq,
   input  wire ufhc_mem_cmd_t memCmd,
   input  wire logic          slowMode,
   output ufhc_mem_rsp_t      memRsp
);
   logic [31:0] mem [logic [31:0]];
   int          waitCnt;
   int          accCnt;
   int          rdCnt;
   int          wrCnt;

   // Idle answer and counters start clear
   initial
   begin
      memRsp  = '0;
      waitCnt = 0;
      accCnt  = 0;
      rdCnt   = 0;
      wrCnt   = 0;
   end

   // One word per request; every second access (2nd, 4th, ...) waits 3 cycles when slow
   always @(posedge clk)
   begin
      memRsp.ack   <= 1'b0;
      memRsp.rdata <= ~memRsp.rdata;  // Data not held once answered
      if (memReq && !memRsp.ack)
      begin
         if (waitCnt >= (slowMode ? 3 * (accCnt % 2) : 0))
         begin
            memRsp.ack <= 1'b1;
            waitCnt    <= 0;
            accCnt     <= accCnt + 1;
            if (memCmd.we)
            begin
               mem[memCmd.addr] = memCmd.wdata;
               wrCnt++;
            end
            else
            begin
               memRsp.rdata <= mem.exists(memCmd.addr) ? mem[memCmd.addr] : 32'h0;
               rdCnt++;
            end
         end
         else
            waitCnt <= waitCnt + 1;
      end
   end
endmodule
